// *** bench/sac_afe_model.sv ***
// Analog front end model: sample-hold, resistor string, comparator
module sac_afe_model (
  input wire logic clk,
  input wire logic cmp_power,
  input wire logic sample_hold,
  input wire logic [9:0] sar_trial_code,
  input wire logic [9:0] level,
  output logic cmp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held = 10'h000;
  logic toggle = 1'b0;
  // Sampler tracks the input while closed and holds it afterwards
  always_ff @(posedge clk) begin
    toggle <= ~toggle;
    if (sample_hold) begin
      held <= level;
    end
  end
  // trial against held level
  // Half-step offset so above and at-or-above give the same code;
  // an unpowered comparator gives a pattern that changes every cycle
  assign cmp_in = cmp_power ? ({held, 1'b1} > {sar_trial_code, 1'b0})
                            : toggle;
endmodule : sac_afe_model

// *** bench/sar_adc_control_and_result_tb.sv ***
// Self-checking bench for the converter control and result block
`include "sac_cfg.svh"
module sar_adc_control_and_result_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic bus_rd = 1'b0;
  logic bus_wr = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [15:0] bus_rdata;
  logic bus_wait, bus_ack, cmp_in, cmp_power, sample_hold;
  logic [9:0] sar_trial_code;
  logic conversion_done_irq, result_unsettled;
  logic [9:0] level = 10'h000;
  int mismatches = 0;
  int checks = 0;
  int irqs = 0;
  int n, k, rw;
  logic [7:0] md;
  logic [15:0] rq;
  int per[11] = '{264, 176, 132, 88, 66, 44, 480, 320, 240, 160, 120};

  always #2 clk = ~clk;

  sac_top u_dut (.clk(clk), .reset(reset), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_wait(bus_wait), .bus_ack(bus_ack),
    .cmp_in(cmp_in), .cmp_power(cmp_power), .sample_hold(sample_hold),
    .sar_trial_code(sar_trial_code),
    .conversion_done_irq(conversion_done_irq),
    .result_unsettled(result_unsettled));

  sac_afe_model u_afe (.clk(clk), .cmp_power(cmp_power),
    .sample_hold(sample_hold), .sar_trial_code(sar_trial_code),
    .level(level), .cmp_in(cmp_in));

  // Completion pulses seen since reset
  always @(posedge clk) begin
    if (conversion_done_irq === 1'b1) begin
      irqs++;
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One strobe cycle, then a bounded wait for acknowledge
  task automatic access(input logic wr, input logic [15:0] a,
                        input logic [7:0] d, output logic [15:0] q,
                        output int w);
    int i;
    w = 0;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = wr;
    bus_rd = ~wr;
    @(posedge clk);
    #1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    for (i = 0; i < 8 && bus_ack !== 1'b1; i++) begin
      w += (bus_wait === 1'b1);
      @(posedge clk);
      #1;
    end
    if (bus_ack !== 1'b1) begin
      mismatches++;
      conclude();
    end
    q = bus_rdata;
  endtask : access

  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp,
                       input int expw, input string what);
    logic [15:0] q;
    int w;
    access(1'b0, a, 8'h00, q, w);
    check(what, exp, q);
    check("wait cycles", 16'(expw), 16'(w));
  endtask : rdchk

  task automatic wrmode(input logic [7:0] d);
    logic [15:0] q;
    int w;
    access(1'b1, `SAC_ADDR_MODE, d, q, w);
    check("mode write wait", 16'h0001, 16'(w));
  endtask : wrmode

  // Cycles up to the next completion pulse, bounded
  task automatic wait_irq(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (conversion_done_irq !== 1'b1 && c < 2000);
    if (conversion_done_irq !== 1'b1) begin
      mismatches++;
      conclude();
    end
  endtask : wait_irq

  initial begin
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    // Reset values, the unmapped hole and a refused result write
    rdchk(`SAC_ADDR_WORD, 16'h0000, 1, "word");
    rdchk(`SAC_ADDR_HIGH, 16'h0000, 1, "high");
    rdchk(`SAC_ADDR_MODE, 16'h0000, 0, "mode");
    rdchk(16'hFF00, 16'h0000, 0, "unmapped");
    access(1'b1, `SAC_ADDR_WORD, 8'hFF, rq, rw);
    check("word write wait", 16'h0000, 16'(rw));
    rdchk(`SAC_ADDR_WORD, 16'h0000, 1, "word");
    // Prohibited range codes with run set must not convert
    wrmode(8'hFF);
    rdchk(`SAC_ADDR_MODE, 16'h00BF, 0, "mode");
    repeat (600) @(posedge clk);
    #1;
    check("irq count", 16'h0000, 16'(irqs));
    // Stop first, keeping the fields, before choosing new ones
    wrmode(8'h3F);
    wrmode(8'hAB);
    repeat (600) @(posedge clk);
    #1;
    check("irq count", 16'h0000, 16'(irqs));
    wrmode(8'h2B);
    wrmode(8'h00);
    check("power stopped", 16'h0000, 16'(cmp_power));
    // Comparator only, then settle well past 1 us before running
    wrmode(8'h01);
    repeat (300) @(posedge clk);
    #1;
    check("power waiting", 16'h0001, 16'(cmp_power));
    check("irq count", 16'h0000, 16'(irqs));
    // Every legal ratio code of both ranges, stopping between changes
    // Bench clock sits far above the analog band; only ratios are checked
    for (k = 0; k < 11; k++) begin
      level = 10'h3FF - 10'(k * 97);
      md = {1'b1, 1'b0, 3'(k < 6 ? k : k - 6), k < 6 ? 2'h0 : 2'h1,
            1'b1};
      wrmode(md);
      wait_irq(n);
      wait_irq(n);
      check("period", 16'(per[k]), 16'(n));
      rdchk(`SAC_ADDR_WORD, {level, 6'h00}, 1, "word");
      rdchk(`SAC_ADDR_HIGH, {8'h00, level[9:2]}, 1, "high");
      check("unsettled", 16'h0000, 16'(result_unsettled));
      wrmode(md & 8'h7F);
    end
    // Run with comparator off flags the first result
    wrmode(8'h00);
    level = 10'h155;
    wrmode(8'hA8);
    wait_irq(n);
    check("unsettled", 16'h0001, 16'(result_unsettled));
    // Stop in mid-conversion: no pulse, result kept
    wait_irq(n);
    check("unsettled", 16'h0000, 16'(result_unsettled));
    level = 10'h2AA;
    // Land the stop inside bit resolution, fields left as they are
    repeat (30) @(posedge clk);
    #1;
    n = irqs;
    wrmode(8'h28);
    repeat (200) @(posedge clk);
    #1;
    check("irq after abort", 16'(n), 16'(irqs));
    check("power stopped", 16'h0000, 16'(cmp_power));
    rdchk(`SAC_ADDR_WORD, {10'h155, 6'h00}, 1, "word");
    conclude();
  end
endmodule : sar_adc_control_and_result_tb

// *** verilog/sac_cfg.svh ***
// Constants for the converter control and result block
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// Bus addresses
`define SAC_ADDR_MODE 16'hFF2A
`define SAC_ADDR_WORD 16'hFF18
`define SAC_ADDR_HIGH 16'hFF1F

// Mode register layout and reset
`define SAC_MODE_RUN 7
`define SAC_MODE_FR_HI 5
`define SAC_MODE_FR_LO 3
`define SAC_MODE_LV_HI 2
`define SAC_MODE_LV_LO 1
`define SAC_MODE_CE 0
`define SAC_MODE_MASK 8'hBF
`define SAC_MODE_RST 8'h00
`define SAC_RESULT_RST 10'h000
`define SAC_RES_PAD 6'h00
`define SAC_BYTE_PAD 8'h00

// Range codes
`define SAC_LV_HIGH 2'h0
`define SAC_LV_LOW 2'h1
`define SAC_FR_MAX_HIGH 3'h5
`define SAC_FR_MAX_LOW 3'h4

// Dividers per ratio code
`define SAC_DIV_0 4'hC
`define SAC_DIV_1 4'h8
`define SAC_DIV_2 4'h6
`define SAC_DIV_3 4'h4
`define SAC_DIV_4 4'h3
`define SAC_DIV_5 4'h2

// Conversion clocks per conversion, and ticks after sampling
`define SAC_TICKS_HIGH 6'h16
`define SAC_TICKS_LOW 6'h28
`define SAC_TAIL_TICKS 6'h0B
`define SAC_SAR_MSB_IDX 4'h9
`define SAC_SAR_MSB 10'h200

// Comparator settling
`define SAC_CLK_NS 4
`define SAC_SETTLE_NS 1000
`define SAC_SETTLE_CYC ((`SAC_SETTLE_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)

`endif

// *** verilog/sac_pkg.sv ***
// Types shared by the converter control and result block
package sac_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_XFER
  } sac_state_e;

  typedef enum logic [1:0] {
    RS_NONE,
    RS_MODE,
    RS_WORD,
    RS_HIGH
  } sac_rsel_e;

  typedef struct packed {
    sac_state_e state;
    logic [7:0] mode;
    logic [9:0] result;
    logic [9:0] sar;
    logic [3:0] idx;
    logic [5:0] tcnt;
    logic [7:0] settle_cnt;
    logic settled;
    logic first_bad;
    logic unsettled;
    logic irq;
    logic cmp_power;
    logic sample;
    sac_rsel_e rsel;
    logic [15:0] rdata;
    logic stall;
    logic ack;
  } sac_state_s;

  typedef struct packed {
    logic [3:0] cnt;
  } sac_div_s;

endpackage : sac_pkg

// *** verilog/sac_tick_div.sv ***
// Conversion clock divider producing a one-cycle tick enable
`include "sac_cfg.svh"
module sac_tick_div (
  input wire logic clk,
  input wire logic reset,
  input wire logic en,
  input wire logic [3:0] div,
  output logic tick
);

  sac_pkg::sac_div_s st;
  sac_pkg::sac_div_s next_st;

  // Tick on the last cycle of each divider period
  assign tick = en && (st.cnt == div - 4'h1);

  // Counter restarts whenever the converter goes idle
  always_comb begin
    next_st = st;
    if (!en || tick) begin
      next_st.cnt = 4'h0;
    end else begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : sac_tick_div

// *** verilog/sac_top.sv ***
// Converter mode register, SAR sequencer and result registers
`include "sac_cfg.svh"
module sac_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_wait,
  output logic bus_ack,
  input wire logic cmp_in,
  output logic cmp_power,
  output logic sample_hold,
  output logic [9:0] sar_trial_code,
  output logic conversion_done_irq,
  output logic result_unsettled
);

  sac_pkg::sac_state_s st;
  sac_pkg::sac_state_s next_st;
  logic run;
  logic ce;
  logic [2:0] fr;
  logic [1:0] lv;
  logic legal;
  logic run_ok;
  logic tick;
  logic [3:0] cur_div;
  logic [5:0] cur_ticks;
  logic [5:0] samp_last;
  sac_pkg::sac_rsel_e sel;

  // Mode fields
  assign run = st.mode[`SAC_MODE_RUN];
  assign ce = st.mode[`SAC_MODE_CE];
  assign fr = st.mode[`SAC_MODE_FR_HI:`SAC_MODE_FR_LO];
  assign lv = st.mode[`SAC_MODE_LV_HI:`SAC_MODE_LV_LO];

  always_comb begin
    case (fr)
      3'h0: cur_div = `SAC_DIV_0;
      3'h1: cur_div = `SAC_DIV_1;
      3'h2: cur_div = `SAC_DIV_2;
      3'h3: cur_div = `SAC_DIV_3;
      3'h4: cur_div = `SAC_DIV_4;
      3'h5: cur_div = `SAC_DIV_5;
      default: cur_div = `SAC_DIV_0;
    endcase
  end

  // Low range: longer tick count, fewer legal codes
  // Prohibited settings simply never start a conversion
  assign legal = (lv == `SAC_LV_HIGH && fr <= `SAC_FR_MAX_HIGH) ||
                 (lv == `SAC_LV_LOW && fr <= `SAC_FR_MAX_LOW);
  assign cur_ticks = (lv == `SAC_LV_LOW) ? `SAC_TICKS_LOW : `SAC_TICKS_HIGH;
  assign samp_last = cur_ticks - `SAC_TAIL_TICKS - 6'h01;
  assign run_ok = run && legal;

  // Address decode
  always_comb begin
    case (bus_addr)
      `SAC_ADDR_MODE: sel = sac_pkg::RS_MODE;
      `SAC_ADDR_WORD: sel = sac_pkg::RS_WORD;
      `SAC_ADDR_HIGH: sel = sac_pkg::RS_HIGH;
      default: sel = sac_pkg::RS_NONE;
    endcase
  end

  // Read data; unmapped reads return zero
  function automatic logic [15:0] rd_mux(input sac_pkg::sac_rsel_e s,
                                        input logic [7:0] m,
                                        input logic [9:0] r);
    case (s)
      sac_pkg::RS_MODE: rd_mux = {`SAC_BYTE_PAD, m};
      sac_pkg::RS_WORD: rd_mux = {r, `SAC_RES_PAD};
      // High byte mirrors the top eight bits
      sac_pkg::RS_HIGH: rd_mux = {`SAC_BYTE_PAD, r[9:2]};
      default: rd_mux = {`SAC_BYTE_PAD, `SAC_BYTE_PAD};
    endcase
  endfunction : rd_mux

  sac_tick_div u_div (
    .clk(clk),
    .reset(reset),
    .en(st.state != sac_pkg::ST_IDLE),
    .div(cur_div),
    .tick(tick)
  );

  always_comb begin
    next_st = st;
    next_st.irq = 1'b0;
    next_st.ack = 1'b0;

    // Second cycle of a waited access completes it
    if (st.stall) begin
      next_st.stall = 1'b0;
      next_st.ack = 1'b1;
      // Word and high-byte views from one result
      next_st.rdata = rd_mux(st.rsel, st.mode, st.result);
    end else if (bus_wr) begin
      next_st.rsel = sac_pkg::RS_NONE;
      next_st.rdata = '0;
      // Mode write; bit 6 is held at zero
      if (sel == sac_pkg::RS_MODE) begin
        next_st.mode = bus_wdata & `SAC_MODE_MASK;
        next_st.stall = 1'b1;
      end else begin
        next_st.ack = 1'b1; // Result registers ignore writes
      end
    end else if (bus_rd) begin
      next_st.rsel = sel;
      // Result views answer only to reads
      if (sel == sac_pkg::RS_WORD || sel == sac_pkg::RS_HIGH) begin
        next_st.stall = 1'b1;
      end else begin
        next_st.ack = 1'b1;
        next_st.rdata = rd_mux(sel, st.mode, st.result);
      end
    end

    // Settling count restarts whenever the comparator is off
    if (!ce) begin
      next_st.settle_cnt = '0;
      next_st.settled = 1'b0;
    end else if (!st.settled) begin
      if (st.settle_cnt == 8'(`SAC_SETTLE_CYC - 1)) begin
        next_st.settled = 1'b1;
      end else begin
        next_st.settle_cnt = st.settle_cnt + 8'h01;
      end
    end

    // Comparator powered when enabled or when the run bit is set, legal range code or not
    next_st.cmp_power = ce || run;

    if (!run_ok) begin
      // Abort leaves result and interrupt untouched
      next_st.state = sac_pkg::ST_IDLE;
    end else begin
      case (st.state)
        sac_pkg::ST_IDLE: begin
          next_st.state = sac_pkg::ST_SAMPLE;
          next_st.tcnt = '0;
          // Comparator not yet settled taints this first result
          next_st.first_bad = !st.settled;
        end
        sac_pkg::ST_SAMPLE: begin
          if (tick) begin
            if (st.tcnt == samp_last) begin
              next_st.state = sac_pkg::ST_CONVERT;
              next_st.sar = `SAC_SAR_MSB;
              next_st.idx = `SAC_SAR_MSB_IDX;
            end else begin
              next_st.tcnt = st.tcnt + 6'h01;
            end
          end
        end
        sac_pkg::ST_CONVERT: begin
          // Keep or drop trial bit, then try the next lower
          if (tick) begin
            next_st.sar[st.idx] = cmp_in;
            if (st.idx == 4'h0) begin
              next_st.state = sac_pkg::ST_XFER;
            end else begin
              next_st.sar[st.idx - 4'h1] = 1'b1;
              next_st.idx = st.idx - 4'h1;
            end
          end
        end
        sac_pkg::ST_XFER: begin
          if (tick) begin
            // Finished value loads the result register
            next_st.result = st.sar;
            // Pulse completion and start over on the same input
            next_st.irq = 1'b1;
            next_st.unsettled = st.first_bad;
            next_st.first_bad = 1'b0;
            next_st.state = sac_pkg::ST_SAMPLE;
            next_st.tcnt = '0;
          end
        end
        default: next_st.state = sac_pkg::ST_IDLE;
      endcase
    end
    next_st.sample = (next_st.state == sac_pkg::ST_SAMPLE);
  end

  // Reset clears mode and both result views
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.mode <= `SAC_MODE_RST;
      st.result <= `SAC_RESULT_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs, all straight from the state register
  assign bus_rdata = st.rdata;
  assign bus_wait = st.stall;
  assign bus_ack = st.ack;
  assign cmp_power = st.cmp_power;
  assign sample_hold = st.sample;
  assign sar_trial_code = st.sar;
  assign conversion_done_irq = st.irq;
  assign result_unsettled = st.unsettled;

  // Helper: cycles since the current conversion began
  int conv_cyc;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_cyc <= 0;
    end else if (st.state == sac_pkg::ST_IDLE) begin
      conv_cyc <= 0;
    end else if (conv_cyc == 0 || st.irq) begin
      conv_cyc <= 1;
    end else begin
      conv_cyc <= conv_cyc + 1;
    end
  end

  chk_stop_mode: assert property (@(posedge clk) disable iff (reset)
    (!run && !ce) |=> (!cmp_power && !sample_hold))
    else $error("stopped converter still active");

  chk_settle_hold: assert property (@(posedge clk) disable iff (reset)
    $rose(ce) |-> (!st.settled)[*8])
    else $error("comparator settled too early");

  chk_conv_length: assert property (@(posedge clk) disable iff (reset)
    (conversion_done_irq && run_ok) |->
      (conv_cyc == int'(cur_div) * int'(cur_ticks)))
    else $error("conversion length wrong");

  chk_low_range: assert property (@(posedge clk) disable iff (reset)
    (lv == `SAC_LV_LOW && fr > `SAC_FR_MAX_LOW) |=>
      (st.state == sac_pkg::ST_IDLE))
    else $error("prohibited low range code converts");

  chk_result_load: assert property (@(posedge clk) disable iff (reset)
    $changed(st.result) |-> (conversion_done_irq &&
      st.result == $past(st.sar)))
    else $error("result changed without completion");

  chk_word_view: assert property (@(posedge clk) disable iff (reset)
    (bus_ack && st.rsel == sac_pkg::RS_WORD) |->
      (bus_rdata == {$past(st.result), `SAC_RES_PAD}))
    else $error("word read data wrong");

  chk_reset_clear: assert property (@(posedge clk) disable iff (reset)
    $past(reset) |-> (st.result == `SAC_RESULT_RST))
    else $error("result not cleared by reset");

  chk_high_view: assert property (@(posedge clk) disable iff (reset)
    (bus_ack && st.rsel == sac_pkg::RS_HIGH) |->
      (bus_rdata == {`SAC_BYTE_PAD, $past(st.result[9:2])}))
    else $error("high byte read data wrong");

  chk_wait_cycle: assert property (@(posedge clk) disable iff (reset)
    (bus_rd && !bus_wr && !bus_wait && sel == sac_pkg::RS_WORD) |=>
      (bus_wait && !bus_ack) ##1 (bus_ack && !bus_wait))
    else $error("result read without one wait cycle");

  chk_repeat_conv: assert property (@(posedge clk) disable iff (reset)
    (conversion_done_irq && run_ok) |-> (st.state == sac_pkg::ST_SAMPLE))
    else $error("conversion did not repeat");

  chk_mode_write: assert property (@(posedge clk) disable iff (reset)
    (bus_wr && !bus_wait && sel == sac_pkg::RS_MODE) |=>
      (st.mode == ($past(bus_wdata) & `SAC_MODE_MASK)))
    else $error("mode register write lost");

  chk_abort: assert property (@(posedge clk) disable iff (reset)
    !run |=> (st.state == sac_pkg::ST_IDLE && !conversion_done_irq))
    else $error("conversion not aborted");

endmodule : sac_top
